// ---- inc/rfd_defines.vh ----
// Constants for the address-matching frame decoder: timing, framing and register map.
`ifndef RFD_DEFINES_VH
`define RFD_DEFINES_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RFD_CLK_FREQ_HZ 250000000
`define RFD_OSC_FREQ_HZ 70000
// Clock cycles per decoder oscillator tick, rounded down.
`define RFD_OSC_DIV (`RFD_CLK_FREQ_HZ / `RFD_OSC_FREQ_HZ)
// High pulse of at least this many ticks is a one sub-bit.
`define RFD_LONG_MIN_TICKS 8'h02
// Low gap of this many ticks marks the pilot before a frame.
`define RFD_SYNC_TICKS 8'h08
// Ticks after the last accepted frame before the valid line drops.
`define RFD_HOLD_TICKS 16'h0200

// ----------------------------------------------------------------------
// Framing
// ----------------------------------------------------------------------
`define RFD_ADDR_SYMS 10
`define RFD_DATA_SYMS 8
`define RFD_SUBBITS 36
`define RFD_TRIT_LOW 2'h0
`define RFD_TRIT_HIGH 2'h1
`define RFD_TRIT_FLOAT 2'h2
`define RFD_TRIT_BAD 2'h3

// ----------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------
`define RFD_REG_CTRL 8'h00
`define RFD_REG_STATUS 8'h04
`define RFD_REG_MASK 8'h08
`define RFD_REG_DATA 8'h0C
`define RFD_CTRL_RESET 1'h1
`define RFD_EV_ACCEPT 0
`define RFD_EV_MISMATCH 1
`define RFD_EV_SYMERR 2
`define RFD_EV_DROP 3
`define RFD_EV_BITS 4
`define RFD_DATA_VALID_BIT 8

`endif

// ---- rtl/rfd_subbit_rx.v ----
// Pulse-width sub-bit detector for the raw receive stream.
`timescale 1ns/1ps
`default_nettype none
`include "rfd_defines.vh"

module rfd_subbit_rx #(
  parameter CW = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst_sync_n,
  // Control
  input wire tick,
  input wire enable,
  input wire rx_in,
  // Results
  output reg bit_valid,
  output reg bit_value,
  output reg sync_seen
);

  reg rx_prev_r;
  reg [CW-1:0] high_cnt_r;
  reg [CW-1:0] low_cnt_r;

  // ----------------------------------------------------------------------
  // Sampling on oscillator ticks
  // ----------------------------------------------------------------------
  // The falling edge closes a sub-bit, so the last one of a frame is
  // decided before the pilot gap of the next frame begins.
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_prev_r <= 1'b0;
      high_cnt_r <= {CW{1'b0}};
      low_cnt_r <= {CW{1'b0}};
      bit_valid <= 1'b0;
      bit_value <= 1'b0;
      sync_seen <= 1'b0;
    end else begin
      bit_valid <= 1'b0;
      sync_seen <= 1'b0;
      if (!enable) begin
        rx_prev_r <= 1'b0;
        high_cnt_r <= {CW{1'b0}};
        low_cnt_r <= {CW{1'b0}};
      end else if (tick) begin
        rx_prev_r <= rx_in;
        if (rx_in) begin
          low_cnt_r <= {CW{1'b0}};
          if (high_cnt_r != {CW{1'b1}}) begin
            high_cnt_r <= high_cnt_r + 1'b1;
          end
        end else begin
          if (rx_prev_r) begin
            bit_valid <= 1'b1;
            bit_value <= (high_cnt_r >= `RFD_LONG_MIN_TICKS);
          end
          high_cnt_r <= {CW{1'b0}};
          if (low_cnt_r != {CW{1'b1}}) begin
            low_cnt_r <= low_cnt_r + 1'b1;
          end
          // One pulse per gap: fires as the gap reaches its length.
          if (low_cnt_r == `RFD_SYNC_TICKS - 8'h01) begin
            sync_seen <= 1'b1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/rfd_decoder.v ----
// Frame decoder: address match against tri-state selects, data outputs, registers.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rfd_defines.vh"

module rfd_decoder #(
  parameter OSC_DIV = `RFD_OSC_DIV,
  parameter [15:0] HOLD_TICKS = `RFD_HOLD_TICKS
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Radio side
  input wire rx_data,
  input wire sleep_request_n,
  output reg raw_rx_out,
  // Local address selects
  input wire [9:0] address_select_level,
  input wire [9:0] address_select_float,
  // Decoded outputs
  output reg [7:0] decoded_out,
  output reg frame_accepted,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Interrupt
  output wire irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RECV = 1'b1;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Decoder oscillator tick
  // ----------------------------------------------------------------------
  reg [15:0] div_cnt_r;
  wire tick = (div_cnt_r == 16'h0000);
  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      div_cnt_r <= 16'h0000;
    end else if (tick) begin
      div_cnt_r <= OSC_DIV[15:0] - 16'h0001;
    end else begin
      div_cnt_r <= div_cnt_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg ctrl_en_r;
  reg [`RFD_EV_BITS-1:0] status_r;
  reg [`RFD_EV_BITS-1:0] status_nxt;
  reg [`RFD_EV_BITS-1:0] mask_r;
  reg [`RFD_EV_BITS-1:0] events;
  wire awake = sleep_request_n & ctrl_en_r;

  // Raw stream bypasses the decoder entirely; only sleep silences it.
  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      raw_rx_out <= 1'b0;
    end else begin
      raw_rx_out <= rx_data & sleep_request_n;
    end
  end

  always @* begin
    status_nxt = status_r;
    if (reg_wr && reg_addr == `RFD_REG_STATUS) begin
      status_nxt = status_nxt & ~reg_wdata[`RFD_EV_BITS-1:0];
    end
    // A new event wins over a clear in the same cycle.
    status_nxt = status_nxt | events;
  end

  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_en_r <= `RFD_CTRL_RESET;
      status_r <= {`RFD_EV_BITS{1'b0}};
      mask_r <= {`RFD_EV_BITS{1'b0}};
      reg_rdata <= 32'h00000000;
    end else begin
      status_r <= status_nxt;
      if (reg_wr && reg_addr == `RFD_REG_CTRL) begin
        ctrl_en_r <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == `RFD_REG_MASK) begin
        mask_r <= reg_wdata[`RFD_EV_BITS-1:0];
      end
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `RFD_REG_CTRL: reg_rdata <= {31'h00000000, ctrl_en_r};
          `RFD_REG_STATUS: reg_rdata <= {28'h0000000, status_r};
          `RFD_REG_MASK: reg_rdata <= {28'h0000000, mask_r};
          `RFD_REG_DATA: reg_rdata <= {23'h000000, frame_accepted, decoded_out};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign irq = |(status_r & mask_r);

  // ----------------------------------------------------------------------
  // Sub-bit recovery
  // ----------------------------------------------------------------------
  wire sb_valid;
  wire sb_value;
  wire sb_sync;
  rfd_subbit_rx #(
    .CW(8)
  ) u_subbit (
    .clk(clk),
    .rst_sync_n(rst_sync_r),
    .tick(tick),
    .enable(awake),
    .rx_in(rx_data),
    .bit_valid(sb_valid),
    .bit_value(sb_value),
    .sync_seen(sb_sync)
  );

  // ----------------------------------------------------------------------
  // Local address as trits
  // ----------------------------------------------------------------------
  reg [19:0] local_trits;
  integer i;
  always @* begin
    local_trits = 20'h00000;
    for (i = 0; i < `RFD_ADDR_SYMS; i = i + 1) begin
      if (address_select_float[i]) begin
        local_trits[2*i +: 2] = `RFD_TRIT_FLOAT;
      end else begin
        local_trits[2*i +: 2] = {1'b0, address_select_level[i]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------------
  // Sub-bits arrive in pairs: 00 low, 11 high, 01 floating (address symbols only, an error in data), 10 invalid.
  reg state_r;
  reg [5:0] sb_cnt_r;
  reg [`RFD_SUBBITS-1:0] shift_r;
  reg frame_done_r;
  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= ST_IDLE;
      sb_cnt_r <= 6'h00;
      shift_r <= {`RFD_SUBBITS{1'b0}};
      frame_done_r <= 1'b0;
    end else begin
      frame_done_r <= 1'b0;
      if (!awake) begin
        state_r <= ST_IDLE;
        sb_cnt_r <= 6'h00;
      end else if (sb_sync) begin
        state_r <= ST_RECV;
        sb_cnt_r <= 6'h00;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sb_cnt_r <= 6'h00;
          end
          ST_RECV: begin
            if (sb_valid) begin
              // First sub-bit lands at the top after the frame fills.
              shift_r <= {shift_r[`RFD_SUBBITS-2:0], sb_value};
              if (sb_cnt_r == `RFD_SUBBITS - 1) begin
                frame_done_r <= 1'b1;
                state_r <= ST_IDLE;
              end else begin
                sb_cnt_r <= sb_cnt_r + 6'h01;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Symbol decode and compare
  // ----------------------------------------------------------------------
  reg [19:0] rx_trits;
  reg [7:0] rx_byte;
  reg sym_err;
  reg [1:0] pair;
  integer k;
  always @* begin
    rx_trits = 20'h00000;
    rx_byte = 8'h00;
    sym_err = 1'b0;
    pair = 2'h0;
    // Symbol k occupies sub-bits 35-2k and 34-2k.
    for (k = 0; k < `RFD_ADDR_SYMS + `RFD_DATA_SYMS; k = k + 1) begin
      pair = shift_r[`RFD_SUBBITS-1-2*k -: 2];
      if (k < `RFD_ADDR_SYMS) begin
        case (pair)
          2'b00: rx_trits[2*k +: 2] = `RFD_TRIT_LOW;
          2'b11: rx_trits[2*k +: 2] = `RFD_TRIT_HIGH;
          2'b01: rx_trits[2*k +: 2] = `RFD_TRIT_FLOAT;
          default: begin
            rx_trits[2*k +: 2] = `RFD_TRIT_BAD;
            sym_err = 1'b1;
          end
        endcase
      end else begin
        case (pair)
          2'b00: rx_byte[k-`RFD_ADDR_SYMS] = 1'b0;
          2'b11: rx_byte[k-`RFD_ADDR_SYMS] = 1'b1;
          default: sym_err = 1'b1;
        endcase
      end
    end
  end

  wire addr_match = (rx_trits == local_trits);

  // ----------------------------------------------------------------------
  // Acceptance, outputs and hold timer
  // ----------------------------------------------------------------------
  reg first_ok_r;
  reg [7:0] first_data_r;
  reg [15:0] hold_cnt_r;
  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      first_ok_r <= 1'b0;
      first_data_r <= 8'h00;
      hold_cnt_r <= 16'h0000;
      decoded_out <= 8'h00;
      frame_accepted <= 1'b0;
      events <= {`RFD_EV_BITS{1'b0}};
    end else begin
      events <= {`RFD_EV_BITS{1'b0}};
      if (!awake) begin
        first_ok_r <= 1'b0;
        frame_accepted <= 1'b0;
        hold_cnt_r <= 16'h0000;
        events[`RFD_EV_DROP] <= frame_accepted;
      end else if (frame_done_r) begin
        if (sym_err) begin
          first_ok_r <= 1'b0;
          events[`RFD_EV_SYMERR] <= 1'b1;
        end else if (!addr_match) begin
          first_ok_r <= 1'b0;
          events[`RFD_EV_MISMATCH] <= 1'b1;
        end else if (first_ok_r && first_data_r == rx_byte) begin
          decoded_out <= rx_byte;
          frame_accepted <= 1'b1;
          hold_cnt_r <= HOLD_TICKS;
          first_data_r <= rx_byte;
          events[`RFD_EV_ACCEPT] <= 1'b1;
        end else begin
          // First of the pair, or data changed: check once more.
          first_ok_r <= 1'b1;
          first_data_r <= rx_byte;
        end
      end else if (tick && hold_cnt_r != 16'h0000) begin
        hold_cnt_r <= hold_cnt_r - 16'h0001;
        if (hold_cnt_r == 16'h0001) begin
          // Outputs keep their last values; only validity lapses.
          frame_accepted <= 1'b0;
          first_ok_r <= 1'b0;
          events[`RFD_EV_DROP] <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/rfd_decoder_assertions.sv ----
// Port-level checks for the frame decoder.
`timescale 1ns/1ps
`default_nettype none
module rfd_decoder_chk #(
  parameter OSC_DIV = 3571,
  parameter [15:0] HOLD_TICKS = 16'h0200
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Radio side
  input wire logic rx_data,
  input wire logic sleep_request_n,
  input wire logic raw_rx_out,
  // Decoded outputs
  input wire logic [7:0] decoded_out,
  input wire logic frame_accepted,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq
);
  logic [1:0] up_r;
  logic [15:0] quiet_r;
  logic ready;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // The design holds its outputs for two edges after release.
  assign ready = (up_r == 2'h3);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_r <= 2'h0;
      quiet_r <= 16'h0;
    end else begin
      if (!ready)
        up_r <= up_r + 2'h1;
      if (rx_data)
        quiet_r <= 16'h0;
      else if (quiet_r != 16'hFFFF)
        quiet_r <= quiet_r + 16'h1;
    end
  end
  sequence s_asleep;
    !sleep_request_n [*3];
  endsequence
  a_raw_rx_follow: assert property (
    ready |-> raw_rx_out == $past(rx_data & sleep_request_n))
    else $error("raw output does not follow the link");
  a_sleep_no_valid: assert property (s_asleep |-> !frame_accepted)
    else $error("valid high while asleep");
  a_valid_awake: assert property (
    $rose(frame_accepted) |-> $past(sleep_request_n, 2))
    else $error("valid rose after sleep");
  a_valid_recent: assert property (
    $rose(frame_accepted) |-> quiet_r <= OSC_DIV * 3 + 4)
    else $error("valid rose without a frame end");
  a_valid_drops: assert property (
    quiet_r > (HOLD_TICKS + 4) * OSC_DIV + 8 |-> !frame_accepted)
    else $error("valid held too long");
  a_data_on_accept: assert property (
    $changed(decoded_out) |-> frame_accepted)
    else $error("data changed without acceptance");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_rdata_data: assert property (
    ready && $past(reg_rd && reg_addr == 8'h0C) |->
      reg_rdata == {23'h0, $past(frame_accepted), $past(decoded_out)})
    else $error("data register differs from outputs");
  a_mask_off_irq: assert property (
    reg_wr && reg_addr == 8'h08 && reg_wdata[3:0] == 4'h0 |=> !irq)
    else $error("irq high with mask clear");
endmodule
bind rfd_decoder rfd_decoder_chk #(
  .OSC_DIV(OSC_DIV),
  .HOLD_TICKS(HOLD_TICKS)
) u_chk (
  .clk(clk), .rst_n(rst_n), .rx_data(rx_data),
  .sleep_request_n(sleep_request_n), .raw_rx_out(raw_rx_out),
  .decoded_out(decoded_out), .frame_accepted(frame_accepted),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
);
`default_nettype wire

// ---- tb/rfd_tx_model.sv ----
// Transmitter model: pilot-led frames of pulse-width sub-bits.
`timescale 1ns/1ps
`default_nettype none
module rfd_tx_model #(
  parameter OSC_DIV = 4
) (
  input wire logic clk,
  output logic rx
);
  initial rx = 1'b0;
  // Levels last whole ticks so the decoder counts them exactly.
  task automatic hold(input logic v, input int n);
    rx <= v;
    repeat (n * OSC_DIV) @(posedge clk);
  endtask
  task automatic sub(input logic b);
    hold(1'b1, b ? 2 : 1);
    hold(1'b0, b ? 1 : 2);
  endtask
  // Bad puts the illegal pair on the first address symbol.
  task automatic send(input logic [9:0] lvl, input logic [9:0] flt,
                      input logic [7:0] dat, input logic bad);
    @(posedge clk);
    hold(1'b0, 10);
    for (int i = 0; i < 10; i++) begin
      sub((bad && i == 0) ? 1'b1 : (flt[i] ? 1'b0 : lvl[i]));
      sub((bad && i == 0) ? 1'b0 : (flt[i] ? 1'b1 : lvl[i]));
    end
    for (int i = 0; i < 8; i++) begin
      sub(dat[i]);
      sub(dat[i]);
    end
    hold(1'b0, 2);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the address-matching frame decoder.
`timescale 1ns/1ps
`default_nettype none
`include "rfd_defines.vh"
module tb_top;
  localparam int DIV = 4;
  localparam logic [9:0] LVL = 10'h2A5;
  localparam logic [9:0] FLT = 10'h0C3;
  logic clk, rst_n, sleep_request_n, reg_wr, reg_rd;
  logic frame_accepted, irq, raw_rx_out, rx;
  logic [7:0] reg_addr, decoded_out;
  logic [31:0] reg_wdata, reg_rdata;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  rfd_tx_model #(.OSC_DIV(DIV)) tx (.clk(clk), .rx(rx));
  // Select pins mix high, low and floating.
  rfd_decoder #(.OSC_DIV(DIV), .HOLD_TICKS(16'h0040)) dut (
    .clk(clk), .rst_n(rst_n), .rx_data(rx),
    .sleep_request_n(sleep_request_n), .raw_rx_out(raw_rx_out),
    .address_select_level(LVL), .address_select_float(FLT),
    .decoded_out(decoded_out), .frame_accepted(frame_accepted),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic pair(input logic [7:0] d);
    tx.send(LVL, FLT, d, 1'b0);
    tx.send(LVL, FLT, d, 1'b0);
    repeat (4) @(posedge clk);
  endtask
  initial begin
    rst_n = 1'b0;
    sleep_request_n = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`RFD_REG_CTRL, 32'h1);
    rd(`RFD_REG_STATUS, 32'h0);
    rd(`RFD_REG_DATA, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    wr(`RFD_REG_MASK, 32'hFFFFFFFF);
    rd(`RFD_REG_MASK, 32'hF);
    pair(8'hA5);
    chk(decoded_out, 8'hA5);
    chk(frame_accepted, 1'b1);
    chk(irq, 1'b1);
    rd(`RFD_REG_DATA, 32'h1A5);
    rd(`RFD_REG_STATUS, 32'h1);
    wr(`RFD_REG_STATUS, 32'hF);
    rd(`RFD_REG_STATUS, 32'h0);
    chk(irq, 1'b0);
    // A mismatch between two lone matches must break the pairing.
    tx.send(LVL, FLT, 8'h3C, 1'b0);
    tx.send(LVL, FLT ^ 10'h008, 8'h3C, 1'b0);
    tx.send(LVL, FLT, 8'h3C, 1'b0);
    repeat (4) @(posedge clk);
    chk(decoded_out, 8'hA5);
    chk(frame_accepted, 1'b0);
    rd(`RFD_REG_STATUS, 32'hA);
    wr(`RFD_REG_STATUS, 32'hF);
    tx.send(LVL, FLT, 8'h3C, 1'b1);
    tx.send(LVL, FLT, 8'h3C, 1'b0);
    repeat (4) @(posedge clk);
    rd(`RFD_REG_STATUS, 32'h4);
    chk(decoded_out, 8'hA5);
    @(posedge clk);
    sleep_request_n <= 1'b0;
    pair(8'h5A);
    rd(`RFD_REG_DATA, 32'h0A5);
    // The symbol error seen before sleep is still pending; nothing new may join it.
    rd(`RFD_REG_STATUS, 32'h4);
    @(posedge clk);
    sleep_request_n <= 1'b1;
    wr(`RFD_REG_CTRL, 32'h0);
    pair(8'h5A);
    rd(`RFD_REG_DATA, 32'h0A5);
    wr(`RFD_REG_CTRL, 32'h1);
    pair(8'h5A);
    rd(`RFD_REG_DATA, 32'h15A);
    wr(`RFD_REG_STATUS, 32'hF);
    repeat (400) @(posedge clk);
    chk(frame_accepted, 1'b0);
    chk(decoded_out, 8'h5A);
    rd(`RFD_REG_STATUS, 32'h8);
    chk(irq, 1'b1);
    wr(`RFD_REG_MASK, 32'h0);
    #1 chk(irq, 1'b0);
    // Sleep while the valid line is high must drop it and keep the data.
    pair(8'hC3);
    chk(frame_accepted, 1'b1);
    @(posedge clk);
    sleep_request_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk(frame_accepted, 1'b0);
    chk(decoded_out, 8'hC3);
    give_verdict();
  end
endmodule
`default_nettype wire
